/* File: src/hcw_consts.svh */
// constants of the hopping code word assembler
`ifndef HCW_CONSTS_SVH
`define HCW_CONSTS_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define HCW_OFS_CONFIG      8'h00
`define HCW_OFS_SERIAL_LO   8'h04
`define HCW_OFS_SERIAL_HI   8'h08
`define HCW_OFS_COUNTER_A   8'h0C
`define HCW_OFS_COUNTER_B   8'h10
`define HCW_OFS_SEED_0      8'h14
`define HCW_OFS_SEED_1      8'h18
`define HCW_OFS_CHECK       8'h1C
`define HCW_OFS_STATUS      8'h20
// ----------------------------------------------------------------
// config word fields
// ----------------------------------------------------------------
`define HCW_CFG_EXT_GUARD   0
`define HCW_CFG_RATE_LO     1
`define HCW_CFG_LEARN_TX    4
`define HCW_CFG_DELAYED     5
`define HCW_CFG_AUTO_OFF    6
`define HCW_CFG_DUAL        7
`define HCW_CFG_USER_A      8
`define HCW_CFG_USER_B      10
`define HCW_CFG_EXT_SERIAL  12
`define HCW_CFG_LEARN_LIM   13
`define HCW_CFG_MANCHESTER  14
`define HCW_CFG_WRAP        15
`define HCW_CFG_RESET       16'h8000
`define HCW_CFG_WMASK       16'h7FF7
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define HCW_CLK_KHZ         10000
`define HCW_TE_BASE_US      100
`define HCW_TE_BASE_CYC     (`HCW_TE_BASE_US * `HCW_CLK_KHZ / 1000)
`define HCW_CARRIER_KHZ     40
`define HCW_CARRIER_HALF    (`HCW_CLK_KHZ / (2 * `HCW_CARRIER_KHZ))
`define HCW_PREAMBLE_ELEMS  23
`define HCW_HEADER_ELEMS    10
`define HCW_GUARD_ELEMS     39
`define HCW_WORD_BITS       67
`define HCW_DELAY_WORDS_S   28
`define HCW_DELAY_WORDS_L   56
`define HCW_TIMEOUT_WORDS_S 256
`define HCW_TIMEOUT_WORDS_L 512
`endif

/* File: src/hcw_pkg.sv */
// types of the hopping code word assembler
package hcw_pkg;
	typedef enum logic [2:0] {
		HCW_IDLE     = 3'b000,
		HCW_LOAD     = 3'b001,
		HCW_PREAMBLE = 3'b010,
		HCW_HEADER   = 3'b011,
		HCW_DATA     = 3'b100,
		HCW_GUARD    = 3'b101,
		HCW_TIMEOUT  = 3'b110
	} hcw_state_e;
	typedef logic [66:0] hcw_word_t;
endpackage : hcw_pkg

/* File: src/hcw_top.sv */
// hopping code word assembler with ahb-lite register slave
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "hcw_consts.svh"

module hcw_top
	import hcw_pkg::*;
#(
	parameter int TE_BASE_CYCLES = `HCW_TE_BASE_CYC
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic [3:0]  button_in,
	input  wire logic        battery_low_flag,
	output logic             tx_data_out,
	output logic             led_on
);

	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------
	function automatic logic [15:0] te_mult(input logic manch, input logic [1:0] rate);
		logic [15:0] m;
		m = 16'h0001;
		case (rate)
			2'b00: m = 16'h0004;
			2'b01: m = 16'h0002;
			2'b10: m = 16'h0002;
			default: m = 16'h0001;
		endcase
		return manch ? {m[14:0], 1'b0} : m;
	endfunction : te_mult

	function automatic logic [7:0] learn_limit(input logic [15:0] start);
		logic [7:0] lim;
		lim = 8'h80;
		if (start == 16'h0060) begin
			lim = 8'h40;
		end else if (start == 16'h0050) begin
			lim = 8'h20;
		end else if (start == 16'h0048) begin
			lim = 8'h10;
		end
		return lim;
	endfunction : learn_limit

	function automatic logic uses_b(input logic dual, input logic [3:0] btn);
		return dual && btn[3];
	endfunction : uses_b

	// ----------------------------------------------------------------
	// register storage
	// ----------------------------------------------------------------
	logic [15:0] cfg_q;
	logic [15:0] ser_lo_q;
	logic [15:0] ser_hi_q;
	logic [15:0] cnt_a_q;
	logic [15:0] cnt_b_q;
	logic [15:0] seed0_q;
	logic [15:0] seed1_q;
	logic [1:0]  check_q;
	logic        wrap_done_q;
	logic [7:0]  lim_a_q;
	logic [7:0]  lim_b_q;
	logic [7:0]  hop_tx_q;
	logic        locked_q;

	logic        wr_pend_q;
	logic [7:0]  wr_addr_q;
	logic [31:0] hrdata_q;

	hcw_state_e  state_q;
	logic [3:0]  btn_q;
	logic [9:0]  words_q;
	logic [15:0] te_q;
	logic [7:0]  elem_q;
	logic [1:0]  phase_q;
	hcw_word_t   word_q;
	logic        tx_q;
	logic        led_q;
	logic [7:0]  car_cnt_q;
	logic        car_q;
	logic        tx_end;

	wire logic ext_guard  = cfg_q[`HCW_CFG_EXT_GUARD];
	wire logic [1:0] rate = cfg_q[`HCW_CFG_RATE_LO +: 2];
	wire logic learn_en   = cfg_q[`HCW_CFG_LEARN_TX];
	wire logic delay_en   = cfg_q[`HCW_CFG_DELAYED];
	wire logic auto_off   = cfg_q[`HCW_CFG_AUTO_OFF];
	wire logic dual       = cfg_q[`HCW_CFG_DUAL];
	wire logic ext_serial = cfg_q[`HCW_CFG_EXT_SERIAL];
	wire logic learn_lim  = cfg_q[`HCW_CFG_LEARN_LIM];
	wire logic manch      = cfg_q[`HCW_CFG_MANCHESTER];
	wire logic wrap_flag  = cfg_q[`HCW_CFG_WRAP];

	// ----------------------------------------------------------------
	// ahb-lite slave: zero wait states, always okay
	// ----------------------------------------------------------------
	wire logic       addr_ok = hsel && hready && htrans[1];
	wire logic       wr_now  = wr_pend_q;
	wire logic [15:0] wdat   = hwdata[15:0];

	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (haddr[7:0] == `HCW_OFS_CONFIG) begin
			rd_mux = {16'h0000, cfg_q};
		end else if (haddr[7:0] == `HCW_OFS_SERIAL_LO) begin
			rd_mux = {16'h0000, ser_lo_q};
		end else if (haddr[7:0] == `HCW_OFS_SERIAL_HI) begin
			rd_mux = {16'h0000, ser_hi_q};
		end else if (haddr[7:0] == `HCW_OFS_COUNTER_A) begin
			rd_mux = {16'h0000, cnt_a_q};
		end else if (haddr[7:0] == `HCW_OFS_COUNTER_B) begin
			rd_mux = {16'h0000, cnt_b_q};
		end else if (haddr[7:0] == `HCW_OFS_SEED_0) begin
			rd_mux = {16'h0000, seed0_q};
		end else if (haddr[7:0] == `HCW_OFS_SEED_1) begin
			rd_mux = {16'h0000, seed1_q};
		end else if (haddr[7:0] == `HCW_OFS_CHECK) begin
			rd_mux = {30'h0000_0000, check_q};
		end else if (haddr[7:0] == `HCW_OFS_STATUS) begin
			rd_mux = {8'h00, hop_tx_q, 2'b00, locked_q, state_q, words_q};
		end
		// back-to-back write then read of the same word sees the new data
		if (wr_now && wr_addr_q == haddr[7:0] && haddr[31:8] == 24'h000000
				&& haddr[7:0] != `HCW_OFS_STATUS) begin
			rd_mux = {16'h0000, wdat};
		end
		if (haddr[31:8] != 24'h000000) begin
			rd_mux = 32'h0000_0000;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
			hrdata_q  <= 32'h0000_0000;
		end else begin
			wr_pend_q <= addr_ok && hwrite && haddr[31:8] == 24'h000000;
			wr_addr_q <= haddr[7:0];
			if (addr_ok && !hwrite) begin
				hrdata_q <= rd_mux;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	assign hrdata = hrdata_q;

	wire logic        use_b   = uses_b(dual, btn_q);
	wire logic [15:0] sel_cnt = use_b ? cnt_b_q : cnt_a_q;

	// ----------------------------------------------------------------
	// configuration and identity words
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_q       <= `HCW_CFG_RESET;
			ser_lo_q    <= 16'h0000;
			ser_hi_q    <= 16'h0000;
			seed0_q     <= 16'h0000;
			seed1_q     <= 16'h0000;
			check_q     <= 2'h0;
			wrap_done_q <= 1'b0;
		end else begin
			if (wr_now && wr_addr_q == `HCW_OFS_CONFIG) begin
				// wrap flag may only be raised until the first rollover
				cfg_q <= {wdat[15] & ~wrap_done_q, wdat[14:0] & 15'(`HCW_CFG_WMASK)};
			end
			if (wr_now && wr_addr_q == `HCW_OFS_SERIAL_LO) ser_lo_q <= wdat;
			if (wr_now && wr_addr_q == `HCW_OFS_SERIAL_HI) ser_hi_q <= wdat;
			if (wr_now && wr_addr_q == `HCW_OFS_SEED_0) seed0_q <= wdat;
			if (wr_now && wr_addr_q == `HCW_OFS_SEED_1) seed1_q <= wdat;
			if (wr_now && wr_addr_q == `HCW_OFS_CHECK) check_q <= wdat[1:0];
			// hardware clear wins over a software write in the same cycle
			if (tx_end && sel_cnt == 16'hFFFF) begin
				cfg_q[`HCW_CFG_WRAP] <= 1'b0;
				wrap_done_q          <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// synchronization counters and learn limit
	// ----------------------------------------------------------------
	logic hop_word;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_a_q <= 16'h0000;
			cnt_b_q <= 16'h0000;
			lim_a_q <= 8'h80;
			lim_b_q <= 8'h80;
		end else begin
			if (wr_now && wr_addr_q == `HCW_OFS_COUNTER_A) begin
				cnt_a_q <= wdat;
				lim_a_q <= learn_limit(wdat);
			end else if (tx_end && !use_b) begin
				cnt_a_q <= cnt_a_q + 16'h0001;
			end
			if (wr_now && wr_addr_q == `HCW_OFS_COUNTER_B) begin
				cnt_b_q <= wdat;
				lim_b_q <= learn_limit(wdat);
			end else if (tx_end && use_b) begin
				cnt_b_q <= cnt_b_q + 16'h0001;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hop_tx_q <= 8'h00;
			locked_q <= 1'b0;
		end else begin
			if (tx_end && hop_word && hop_tx_q != 8'hFF) begin
				hop_tx_q <= hop_tx_q + 8'h01;
			end
			if (learn_lim && hop_tx_q >= (dual ? lim_b_q : lim_a_q)) begin
				locked_q <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// code word assembly
	// ----------------------------------------------------------------
	wire logic [9:0] delay_words = rate[0] ? 10'(`HCW_DELAY_WORDS_L)
	                                       : 10'(`HCW_DELAY_WORDS_S);
	wire logic [9:0] tmo_words   = rate[0] ? 10'(`HCW_TIMEOUT_WORDS_L)
	                                       : 10'(`HCW_TIMEOUT_WORDS_S);
	wire logic delayed = words_q >= delay_words;

	// learn-value words replace the hopping part and the lower serial half on the two learn codes
	wire logic learn_now = learn_en && !locked_q &&
		(btn_q == 4'b1001 || (btn_q == 4'b0011 && delayed));
	assign hop_word = !learn_now;

	logic [7:0]  disc;
	logic [31:0] enc_blk;
	logic [31:0] ser_tx;
	hcw_word_t   word_d;
	always_comb begin
		disc = ser_lo_q[7:0];
		if (delay_en && delayed) begin
			disc[3:0] = ~ser_lo_q[3:0];
		end
		// cipher stage sits outside this block; the plain block goes out here
		enc_blk = {btn_q, (use_b ? cfg_q[`HCW_CFG_USER_B +: 2] : cfg_q[`HCW_CFG_USER_A +: 2]),
		           wrap_flag, dual, disc, sel_cnt};
		if (ext_serial) begin
			ser_tx = {ser_hi_q, ser_lo_q};
		end else begin
			ser_tx = {btn_q, ser_hi_q[11:0], ser_lo_q};
		end
		word_d = {check_q, battery_low_flag, ser_tx, enc_blk};
		if (learn_now) begin
			word_d = {check_q, battery_low_flag,
			          (ext_serial ? ser_hi_q : {btn_q, ser_hi_q[11:0]}),
			          cnt_b_q, seed1_q, seed0_q};
		end
	end

	// ----------------------------------------------------------------
	// element timer and carrier
	// ----------------------------------------------------------------
	wire logic [15:0] te_len = 16'(TE_BASE_CYCLES) * te_mult(manch, rate);
	wire logic        tick   = (te_q == 16'h0000);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			te_q <= 16'h0000;
		end else if (state_q == HCW_LOAD || tick) begin
			te_q <= te_len - 16'h0001;
		end else begin
			te_q <= te_q - 16'h0001;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			car_cnt_q <= 8'h00;
			car_q     <= 1'b1;
		end else if (car_cnt_q == 8'(`HCW_CARRIER_HALF - 1)) begin
			car_cnt_q <= 8'h00;
			car_q     <= ~car_q;
		end else begin
			car_cnt_q <= car_cnt_q + 8'h01;
		end
	end

	// ----------------------------------------------------------------
	// transmission sequencer
	// ----------------------------------------------------------------
	wire logic new_btn   = |(button_in & ~btn_q);
	wire logic last_ph   = manch ? (phase_q == 2'd1) : (phase_q == 2'd2);
	wire logic [9:0] min_words = ext_guard ? 10'd4 : 10'd2;
	wire logic word_done = state_q == HCW_GUARD && tick &&
		elem_q == 8'(`HCW_GUARD_ELEMS - 1);
	wire logic abort     = new_btn && state_q != HCW_IDLE && state_q != HCW_TIMEOUT
		&& state_q != HCW_LOAD;
	wire logic stop      = word_done && button_in == 4'h0 && (words_q + 10'd1) >= min_words;
	wire logic time_up   = word_done && auto_off && (words_q + 10'd1) >= tmo_words;

	assign tx_end = abort || stop || time_up;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= HCW_IDLE;
			btn_q   <= 4'h0;
			words_q <= 10'h000;
			elem_q  <= 8'h00;
			phase_q <= 2'h0;
			word_q  <= '0;
		end else begin
			case (state_q)
				HCW_IDLE: begin
					if (button_in != 4'h0) begin
						btn_q   <= button_in;
						words_q <= 10'h000;
						state_q <= HCW_LOAD;
					end
				end
				HCW_LOAD: begin
					word_q  <= word_d;
					elem_q  <= 8'h00;
					phase_q <= 2'h0;
					state_q <= HCW_PREAMBLE;
				end
				HCW_PREAMBLE: begin
					if (tick) begin
						elem_q <= elem_q + 8'h01;
						if (elem_q == 8'(`HCW_PREAMBLE_ELEMS - 1)) begin
							elem_q  <= 8'h00;
							state_q <= HCW_HEADER;
						end
					end
				end
				HCW_HEADER: begin
					if (tick) begin
						elem_q <= elem_q + 8'h01;
						if (elem_q == 8'(`HCW_HEADER_ELEMS - 1)) begin
							elem_q  <= 8'h00;
							state_q <= HCW_DATA;
						end
					end
				end
				HCW_DATA: begin
					if (tick) begin
						phase_q <= phase_q + 2'h1;
						if (last_ph) begin
							phase_q <= 2'h0;
							elem_q  <= elem_q + 8'h01;
							word_q  <= {1'b0, word_q[66:1]};
							if (elem_q == 8'(`HCW_WORD_BITS - 1)) begin
								elem_q  <= 8'h00;
								state_q <= HCW_GUARD;
							end
						end
					end
				end
				HCW_GUARD: begin
					if (tick) begin
						elem_q <= elem_q + 8'h01;
					end
					if (word_done) begin
						words_q <= words_q + 10'd1;
						if (time_up) begin
							state_q <= HCW_TIMEOUT;
						end else if (stop) begin
							state_q <= HCW_IDLE;
						end else begin
							state_q <= HCW_LOAD;
						end
					end
				end
				HCW_TIMEOUT: begin
					if (button_in == 4'h0) begin
						state_q <= HCW_IDLE;
					end
				end
				default: begin
					state_q <= HCW_IDLE;
				end
			endcase
			// removed buttons are ignored; only a new one restarts
			if (abort) begin
				btn_q   <= btn_q | button_in;
				state_q <= HCW_LOAD;
			end
		end
	end

	// ----------------------------------------------------------------
	// output stage
	// ----------------------------------------------------------------
	wire logic skip = ext_guard && words_q[0];
	wire logic ir   = dual && btn_q[3] && btn_q[2];
	logic level;
	always_comb begin
		level = 1'b0;
		case (state_q)
			HCW_PREAMBLE: level = ~elem_q[0];
			HCW_DATA: begin
				if (manch) begin
					level = (phase_q == 2'h0) ? word_q[0] : ~word_q[0];
				end else begin
					level = (phase_q == 2'h0) | ((phase_q == 2'h1) & ~word_q[0]);
				end
			end
			default: level = 1'b0;
		endcase
		if (skip) begin
			level = 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_q  <= 1'b0;
			led_q <= 1'b0;
		end else begin
			tx_q  <= level & (ir ? car_q : 1'b1);
			led_q <= !skip && (state_q == HCW_PREAMBLE || state_q == HCW_HEADER
				|| state_q == HCW_DATA);
		end
	end

	assign tx_data_out = tx_q;
	assign led_on      = led_q;

endmodule : hcw_top
`default_nettype wire

/* File: bench/hcw_chk_sva.sv */
// port checker of the code word assembler
`timescale 1ns/1ps
`default_nettype none
module hcw_chk #(
	parameter int TE_BASE_CYCLES = 4
) (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [3:0]  button_in,
	input wire logic        tx_data_out,
	input wire logic        led_on
);
	// ----------------------------------------------------------------
	// low run inside a word, longest is the header
	// ----------------------------------------------------------------
	int lo_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lo_q <= 0;
		end else begin
			lo_q <= (led_on && !tx_data_out) ? lo_q + 1 : 0;
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	AST_READY: assert property (hreadyout) else $error("wait state seen");
	AST_OKAY: assert property (!hresp) else $error("error response seen");
	AST_UPPER_ZERO: assert property (hrdata[31:16] == 16'h0000) else $error("upper half set");
	AST_SILENT_IDLE: assert property (!led_on |-> !tx_data_out)
		else $error("output high outside a word");
	AST_START: assert property ($past(button_in) == 4'h0 && button_in != 4'h0 && !led_on
		|-> ##[1:6] led_on) else $error("press did not start a word");
	// limitation: holds for base periods of four cycles or more, carrier off
	AST_PULSE_MIN: assert property ($rose(tx_data_out) |-> tx_data_out [*4])
		else $error("element shorter than base period");
	AST_PREAMBLE_HIGH: assert property ($rose(led_on) |-> ##[0:1] tx_data_out)
		else $error("preamble not starting high");
	AST_WORD_MIN: assert property ($rose(led_on) |-> led_on [*8])
		else $error("word too short");
	AST_LOW_RUN: assert property (lo_q <= 80 * TE_BASE_CYCLES)
		else $error("low run inside word too long");
endmodule : hcw_chk
bind hcw_top hcw_chk #(.TE_BASE_CYCLES(TE_BASE_CYCLES)) u_chk (.hclk(hclk), .hresetn(hresetn),
	.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .button_in(button_in),
	.tx_data_out(tx_data_out), .led_on(led_on));
`default_nettype wire

/* File: bench/hcw_rx_model.sv */
// receiver model decoding pulse-width code words
`timescale 1ns/1ps
`default_nettype none
module hcw_rx_model #(
	parameter int TE = 4
) (
	input  wire logic        clk,
	input  wire logic        tx,
	output logic      [66:0] word,
	output int               words
);
	int          hi_n = 0;
	int          lo_n = 0;
	int          nbits = 99;
	int          hl = 0;
	logic [66:0] sh = '0;
	initial word = '0;
	initial words = 0;
	always @(posedge clk) begin
		if (tx) begin
			hi_n <= hi_n + 1;
			lo_n <= 0;
			// every bit spans three elements; anything else means the word was cut
			if (hi_n == 0 && nbits > 0 && nbits < 67 && hl + lo_n != 3 * TE)
				nbits <= 99;
			// a header gap, not the guard, opens the data bits
			if (hi_n == 0 && lo_n >= 8 * TE && lo_n <= 20 * TE)
				nbits <= 0;
		end else begin
			lo_n <= lo_n + 1;
			hi_n <= 0;
			// short high is a one, long high a zero, lsb first
			if (hi_n > 0 && nbits < 67) begin
				sh[nbits] <= (hi_n * 2 < 3 * TE);
				nbits     <= nbits + 1;
				hl        <= hi_n;
			end
		end
		if (nbits == 67) begin
			word  <= sh;
			words <= words + 1;
			nbits <= 99;
		end
	end
endmodule : hcw_rx_model
`default_nettype wire

/* File: bench/testbench.sv */
// self-checking bench of the code word assembler
`timescale 1ns/1ps
`default_nettype none
module testbench;
	typedef struct packed {logic [7:0] a; logic [31:0] d; logic [15:0] q;} hcw_row_s;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = '0;
	logic [1:0]  htrans = '0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = '0;
	logic        hready;
	logic [31:0] hrdata;
	logic        hresp;
	logic [3:0]  button_in = '0;
	logic        tx_data_out;
	logic        led_on;
	logic [66:0] rx_word;
	int          rx_words;
	int          num_errors = 0;
	int          tests_run = 0;
	logic [31:0] q;
	int          w0;
	hcw_row_s    rows [9] = '{'{8'h04, 32'h1234ABCD, 16'hABCD}, '{8'h08, 32'hFFFF5678, 16'h5678},
		'{8'h0C, 32'h10, 16'h10}, '{8'h10, 32'hFF, 16'hFF}, '{8'h1C, 32'h7, 16'h3},
		'{8'h00, 32'hE, 16'h0006}, '{8'h44, 32'hFFFF, 16'h0},
		'{8'h14, 32'h1111, 16'h1111}, '{8'h18, 32'h2222, 16'h2222}};
	initial forever #50 hclk = ~hclk;
	hcw_top #(.TE_BASE_CYCLES(4)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
		.hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
		.button_in(button_in), .battery_low_flag(1'b1), .tx_data_out(tx_data_out),
		.led_on(led_on));
	hcw_rx_model #(.TE(4)) u_rx (.clk(hclk), .tx(tx_data_out), .word(rx_word), .words(rx_words));
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic complete_run;
		if (num_errors == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : complete_run
	task automatic chk(input logic [66:0] e, input logic [66:0] g, input string nm);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic bust(input string nm);
		num_errors++;
		$display("BAD %s expected done seen timeout", nm);
		complete_run();
	endtask : bust
	task automatic rdy;
		int n;
		n = 0;
		@(posedge hclk);
		while (hready !== 1'b1) begin
			if (++n > 50) bust("hready");
			@(posedge hclk);
		end
	endtask : rdy
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		haddr  <= {24'h0, a};
		hwrite <= wr;
		hsel   <= 1'b1;
		htrans <= 2'b10;
		rdy();
		htrans <= 2'b00;
		hwdata <= d;
		rdy();
		q = hrdata;
	endtask : bus
	task automatic wait_words(input int n);
		int k;
		k = 0;
		while (rx_words < n) begin
			if (++k > 3000) bust("word count");
			@(posedge hclk);
		end
	endtask : wait_words
	// short press, two words, then silence and one counter step
	task automatic send(input logic [15:0] cfg, input logic [3:0] b, input logic [66:0] e,
		input logic [7:0] ca, input logic [15:0] ce);
		bus(1'b1, 8'h00, {16'h0, cfg});
		w0 = rx_words;
		button_in <= b;
		repeat (20) @(posedge hclk);
		button_in <= 4'h0;
		wait_words(w0 + 2);
		repeat (200) @(posedge hclk);
		chk(e, rx_word, "code word");
		chk(67'(w0 + 2), 67'(rx_words), "word count");
		chk(67'h0, 67'(led_on), "led after release");
		bus(1'b0, ca, 32'h0);
		chk(67'(ce), 67'(q), "counter");
	endtask : send
	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int i = 0; i < 9; i++) begin
			bus(1'b1, rows[i].a, rows[i].d);
			bus(1'b0, rows[i].a, 32'h0);
			chk(67'(rows[i].q), 67'(q), "register");
		end
		send(16'h000E, 4'h2, {3'b111, 4'h2, 28'h678ABCD, 8'h20, 8'hCD, 16'h0010}, 8'h0C, 16'h0011);
		send(16'h100E, 4'h4, {3'b111, 32'h5678ABCD, 8'h40, 8'hCD, 16'h0011}, 8'h0C, 16'h0012);
		send(16'h008E, 4'h8, {3'b111, 4'h8, 28'h678ABCD, 8'h81, 8'hCD, 16'h00FF}, 8'h10, 16'h0100);
		// a second button mid-word restarts with the new code
		w0 = rx_words;
		button_in <= 4'h1;
		repeat (300) @(posedge hclk);
		button_in <= 4'h3;
		wait_words(w0 + 1);
		chk(67'h3, 67'(rx_word[31:28]), "button after abort");
		chk(67'h13, 67'(rx_word[15:0]), "counter after abort");
		button_in <= 4'h0;
		wait_words(w0 + 2);
		repeat (200) @(posedge hclk);
		// rollover clears the wrap flag for good
		bus(1'b1, 8'h0C, 32'hFFFF);
		send(16'h800E, 4'h2, {3'b111, 4'h2, 28'h678ABCD, 8'h22, 8'hCD, 16'hFFFF}, 8'h0C, 16'h0000);
		bus(1'b1, 8'h00, 32'h800E);
		bus(1'b0, 8'h00, 32'h0);
		chk(67'h6, 67'(q), "wrap flag after rollover");
		// learn code with learn enabled keeps dual mode off
		send(16'h0016, 4'h9, {3'b111, 16'h9678, 16'h0100, 16'h2222, 16'h1111}, 8'h0C, 16'h0001);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		chk(67'h0, 67'({tx_data_out, led_on}), "outputs in reset");
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(1'b0, 8'h00, 32'h0);
		chk(67'h8000, 67'(q), "config after reset");
		complete_run();
	end
endmodule : testbench
`default_nettype wire
